// ===== hw/deadman_discharge_supervisor.sv
`include "deadman_cfg.svh"
module deadman_discharge_supervisor
   import deadman_pkg::*;
#(
   parameter int SEC_CYC    = `SEC_CYCLES,
   parameter int RETRIG_CYC = `RETRIG_CYCLES,
   parameter int BLINK_CYC  = `BLINK_CYCLES,
   parameter int LOG_DEPTH  = `LOG_DEPTH
) (
   input  wire logic                        clock,
   input  wire logic                        rst,
   input  wire logic                        ce,
   input  deadman_pkg::keys_t               keys_pin,
   input  wire logic                        flow_computer_present,
   input  deadman_pkg::valve_mode_t         valve_control_setting,
   input  deadman_pkg::dm_setting_t         deadman_setting,
   input  wire logic                        bypass_request,
   input  wire logic                        remote_power_on,
   input  wire logic                        log_clear,
   input  wire logic                        radio_nodes_changed,
   input  wire logic                        discharge_finished,
   input  wire logic [$clog2(LOG_DEPTH)-1:0] log_rd_addr,
   input  wire logic                        amp_on,
   input  wire logic                        in_charger,
   input  wire logic                        sensor_connected,
   input  wire logic                        sensor_wet,
   input  wire logic                        sensor_warming,
   input  wire logic                        radio_ok,
   input  wire logic                        func_fault,
   input  wire logic                        batt_full,
   input  wire logic                        batt_fault,
   output logic                             discharge_active,
   output logic                             deadman_warning,
   output logic                             forced_stop,
   output logic                             retrigger_msg,
   output logic                             machine_off,
   output logic                             bypass_active,
   output logic                             unroll_out,
   output logic                             rollup_out,
   output logic                             fill_release,
   output logic                             amp_auto_off,
   output deadman_pkg::leds_t               amp_leds,
   output deadman_pkg::log_entry_t          log_rd_data,
   output logic [$clog2(LOG_DEPTH):0]       log_count
);
   localparam int AW = $clog2(LOG_DEPTH);

   typedef struct packed {
      keys_t       k1;
      keys_t       k2;
      keys_t       kd;
      logic        run;
      logic        finished;
      logic        warn;
      logic        forced;
      logic [31:0] sec_cnt;
      logic [7:0]  idle_s;
      logic [31:0] rt_cnt;
      logic        rt;
      logic        bypass;
      logic        bypass_used;
      logic [31:0] bypass_s;
      logic [31:0] now_s;
      logic        shift_armed;
      logic        unroll;
      logic        rollup;
      logic        mach_off;
      logic        wr;
      log_entry_t  wr_data;
      logic [AW-1:0] wr_ptr;
      logic [AW:0] count;
      logic        rel_d;
   } st_t;
   st_t s_r, s_nxt;

   keys_t press;
   logic  dm_enabled;
   logic  start_evt;
   logic  stop_evt;
   logic  rel;

   function automatic log_entry_t make_entry(input logic [1:0] code, input logic [31:0] ts,
                                             input logic [31:0] dur);
      make_entry = '{stamp: ts, duration: dur, event_code: code};
   endfunction : make_entry

   amp_status #(
      .SEC_CYC   (SEC_CYC),
      .BLINK_CYC (BLINK_CYC)
   ) u_amp (
      .clock            (clock),
      .rst              (rst),
      .ce               (ce),
      .amp_on           (amp_on),
      .in_charger       (in_charger),
      .sensor_connected (sensor_connected),
      .sensor_wet       (sensor_wet),
      .sensor_warming   (sensor_warming),
      .radio_ok         (radio_ok),
      .func_fault       (func_fault),
      .batt_full        (batt_full),
      .batt_fault       (batt_fault),
      .fill_release     (rel),
      .auto_off         (amp_auto_off),
      .leds             (amp_leds)
   );

   log_memory #(
      .DEPTH (LOG_DEPTH),
      .WIDTH ($bits(log_entry_t))
   ) u_log (
      .clock   (clock),
      .rst     (rst),
      .ce      (ce),
      .wr_en   (s_r.wr),
      .wr_addr (s_r.wr_ptr),
      .wr_data (s_r.wr_data),
      .rd_addr (log_rd_addr),
      .rd_data (log_rd_data)
   );

   // key pins pass two flops, then edge detect
   assign press      = s_r.k2 & ~s_r.kd;
   // (R6) (R10) supervision off or bypassed
   assign dm_enabled = (deadman_setting != DM_OFF) && !s_r.bypass;

   always_comb begin
      s_nxt       = s_r;
      s_nxt.k1    = keys_pin;
      s_nxt.k2    = s_r.k1;
      s_nxt.kd    = s_r.k2;
      s_nxt.wr    = 1'b0;
      s_nxt.rt    = 1'b0;
      s_nxt.rel_d = rel;
      if (s_r.sec_cnt >= 32'(SEC_CYC - 1)) begin
         s_nxt.sec_cnt = '0;
         s_nxt.now_s   = s_r.now_s + 32'h1;
      end else begin
         s_nxt.sec_cnt = s_r.sec_cnt + 32'h1;
      end
      // (R4) start source
      if (flow_computer_present || valve_control_setting == VALVE_VIA_KEY) begin
         start_evt = press.start_key;
      end else begin
         start_evt = rel && !s_r.rel_d;
      end
      // (R5) stop and emergency stop
      stop_evt = press.stop_key || press.estop_key;
      if (press.estop_key) begin
         s_nxt.mach_off = 1'b1;
      end else if (start_evt) begin
         s_nxt.mach_off = 1'b0;
      end
      if (!s_r.run) begin
         // (R23) timing idle without discharge
         s_nxt.idle_s = '0;
         s_nxt.warn   = 1'b0;
         s_nxt.rt_cnt = '0;
         if (start_evt && !stop_evt && !s_r.finished && !sensor_wet) begin
            // (R1) (R9) start arms timing, resumes
            s_nxt.run     = 1'b1;
            s_nxt.forced  = 1'b0;
            s_nxt.sec_cnt = '0;
         end
      end else begin
         if (stop_evt || discharge_finished) begin
            s_nxt.run      = 1'b0;
            s_nxt.finished = 1'b1;
            s_nxt.warn     = 1'b0;
         end else if (sensor_wet || !radio_ok) begin
            // (R16) (R22) wet or link loss pauses
            s_nxt.run  = 1'b0;
            s_nxt.warn = 1'b0;
         end else if (dm_enabled) begin
            if (press.deadman_key) begin
               // (R2) (R8) key press restarts interval
               s_nxt.idle_s  = '0;
               s_nxt.warn    = 1'b0;
               s_nxt.sec_cnt = '0;
            end else if (s_r.sec_cnt == '0) begin
               s_nxt.idle_s = s_r.idle_s + 8'h1;
               // (R7) warning after idle time
               if (s_r.idle_s + 8'h1 >= 8'(`WARN_TIME_S)) begin
                  s_nxt.warn = 1'b1;
               end
               // (R9) forced stop after grace
               if (s_r.idle_s + 8'h1 >= 8'(`WARN_TIME_S + `FORCE_TIME_S)) begin
                  s_nxt.run    = 1'b0;
                  s_nxt.forced = 1'b1;
                  s_nxt.warn   = 1'b0;
               end
            end
            // (R3) periodic retrigger
            if (s_r.rt_cnt >= 32'(RETRIG_CYC - 1)) begin
               s_nxt.rt_cnt = '0;
               s_nxt.rt     = flow_computer_present;
            end else begin
               s_nxt.rt_cnt = s_r.rt_cnt + 32'h1;
            end
         end else begin
            s_nxt.idle_s = '0;
            s_nxt.warn   = 1'b0;
         end
      end
      if (s_r.finished && (start_evt && !s_r.run) && !s_r.forced) begin
         s_nxt.finished = 1'b0;
      end
      // (R10) bypass for one discharge
      if (bypass_request && deadman_setting == DM_ON_BYPASS && !s_r.bypass && !s_r.bypass_used) begin
         s_nxt.bypass   = 1'b1;
         s_nxt.bypass_s = s_r.now_s;
         // (R12) log bypass start with zero duration; duration logged at discharge end
         s_nxt.wr      = 1'b1;
         s_nxt.wr_data = make_entry(`LOG_EV_BYPASS, s_r.now_s, '0);
      end
      if (s_r.run && !s_nxt.run && s_r.finished == 1'b0 && s_nxt.finished && s_r.bypass) begin
         s_nxt.bypass      = 1'b0;
         s_nxt.bypass_used = 1'b0;
         s_nxt.wr          = 1'b1;
         s_nxt.wr_data     = make_entry(`LOG_EV_BYPASS, s_r.bypass_s, s_r.now_s - s_r.bypass_s);
      end
      // (R11) power off clears bypass
      if (!remote_power_on) begin
         s_nxt.bypass      = 1'b0;
         s_nxt.bypass_used = 1'b0;
      end
      // (R13) log clear and node changes
      if (log_clear) begin
         s_nxt.count   = '0;
         s_nxt.wr      = 1'b1;
         s_nxt.wr_data = make_entry(`LOG_EV_CLEAR, s_r.now_s, '0);
      end else if (radio_nodes_changed && !s_nxt.wr) begin
         s_nxt.wr      = 1'b1;
         s_nxt.wr_data = make_entry(`LOG_EV_NODES, s_r.now_s, '0);
      end
      if (s_r.wr) begin
         s_nxt.wr_ptr = s_r.wr_ptr + AW'(1);
         if (s_r.count != (AW+1)'(LOG_DEPTH) && !log_clear) begin
            s_nxt.count = s_r.count + (AW+1)'(1);
         end
      end
      // hose keys: shift toggles arming, next key drives
      if (press.shift_key) begin
         s_nxt.shift_armed = ~s_r.shift_armed;
      end
      // (R14) unroll only with no discharge
      s_nxt.unroll = !s_r.run && s_r.k2.unroll_key
                     && (s_r.unroll || (press.unroll_key && s_r.shift_armed));
      // (R15) roll-up only after finish
      s_nxt.rollup = s_r.finished && !s_r.run && s_r.k2.rollup_key
                     && (s_r.rollup || (press.rollup_key && s_r.shift_armed));
      if (press.unroll_key || press.rollup_key) begin
         s_nxt.shift_armed = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign discharge_active = s_r.run;
   assign deadman_warning  = s_r.warn;
   assign forced_stop      = s_r.forced;
   assign retrigger_msg    = s_r.rt;
   assign machine_off      = s_r.mach_off;
   assign bypass_active    = s_r.bypass;
   assign unroll_out       = s_r.unroll;
   assign rollup_out       = s_r.rollup;
   assign fill_release     = rel;
   assign log_count        = s_r.count;

   property p_off_quiet;
      @(posedge clock) disable iff (rst) deadman_setting == DM_OFF |-> !s_nxt.warn && !(s_nxt.forced && !s_r.forced);
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("supervision active while off"); // (R6)
   property p_idle_quiet;
      @(posedge clock) disable iff (rst) !discharge_active |-> !deadman_warning;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("warning without discharge"); // (R23)
   property p_warn_time;
      @(posedge clock) disable iff (rst) $rose(deadman_warning) |-> s_r.idle_s == 8'(`WARN_TIME_S);
   endproperty
   a_warn_time: assert property (p_warn_time) else $error("warning at wrong time"); // (R7)
   property p_force_time;
      @(posedge clock) disable iff (rst) $rose(forced_stop) |-> $past(s_r.idle_s) == 8'(`WARN_TIME_S + `FORCE_TIME_S - 1);
   endproperty
   a_force_time: assert property (p_force_time) else $error("forced stop at wrong time"); // (R9)
   property p_dm_restart;
      @(posedge clock) disable iff (rst) ce && discharge_active && press.deadman_key && dm_enabled
         && !stop_evt && !discharge_finished && !sensor_wet && radio_ok |=> s_r.idle_s == 8'h0 && !deadman_warning;
   endproperty
   a_dm_restart: assert property (p_dm_restart) else $error("key press did not restart"); // (R2)
   property p_unroll_idle;
      @(posedge clock) disable iff (rst) unroll_out |-> $past(!discharge_active);
   endproperty
   a_unroll_idle: assert property (p_unroll_idle) else $error("unroll during discharge"); // (R14)
   property p_rollup_done;
      @(posedge clock) disable iff (rst) rollup_out |-> $past(s_r.finished);
   endproperty
   a_rollup_done: assert property (p_rollup_done) else $error("roll-up before finish"); // (R15)
   property p_bypass_off;
      @(posedge clock) disable iff (rst) ce && !remote_power_on |=> !bypass_active;
   endproperty
   a_bypass_off: assert property (p_bypass_off) else $error("bypass kept after power off"); // (R11)
   property p_estop;
      @(posedge clock) disable iff (rst) ce && press.estop_key |=> machine_off && !discharge_active;
   endproperty
   a_estop: assert property (p_estop) else $error("emergency stop ignored"); // (R5)
   property p_bypass_log;
      @(posedge clock) disable iff (rst) $rose(bypass_active) |-> $past(s_nxt.wr);
   endproperty
   a_bypass_log: assert property (p_bypass_log) else $error("bypass not logged"); // (R12)
   c_warn: cover property (@(posedge clock) disable iff (rst) $rose(deadman_warning));
   c_forced: cover property (@(posedge clock) disable iff (rst) $rose(forced_stop));
   c_unroll: cover property (@(posedge clock) disable iff (rst) $rose(unroll_out));
endmodule : deadman_discharge_supervisor

// ===== hw/deadman_cfg.svh
`ifndef DEADMAN_CFG_SVH
`define DEADMAN_CFG_SVH
// What this block does
// (R1) supervision timing starts together with the discharge start
// (R2) each dead-man key press restarts the supervision interval
// (R3) periodic retrigger messages to flow computer while enabled and discharging
// (R4) stand-alone start by start key or amplifier release per valve setting
// (R5) stop key stops; emergency stop also stops and switches off machine
// (R6) dead-man setting off means no supervision, warning or forced stop
// (R7) thirty seconds without key press raises optical warning
// (R8) key press within ten seconds of warning clears it, restarts interval
// (R9) ten seconds after warning without press forces stop; start resumes
// (R10) bypass option suspends supervision for one discharge only
// (R11) switching remote system off clears an active bypass
// (R12) bypass activation logs timestamp and bypass duration
// (R13) log also records log clearing and radio node changes
// (R14) unroll output only without discharge, after shift then held unroll key
// (R15) roll-up output only after discharge end, shift then held roll-up key
// (R16) dry sensor gives release and green; wet stops discharge, lights red
// (R17) charging insertion lights all indicators for seconds during battery test
// (R18) charging: power dark, green full, red charging, both fault
// (R19) operation: power steady when on, blinks without radio link
// (R20) operation: green blinks warming, red blinks after function fault
// (R21) amplifier switches off after over two minutes without sensor
// (R22) radio link loss during discharge pauses discharge
// (R23) timing idle without discharge; warning cleared when discharge ends
`define CLK_HZ          40000000
`define WARN_TIME_S     30
`define FORCE_TIME_S    10
`define SENSOR_LOSS_S   120
`define LAMP_TEST_S     3
`define RETRIG_MS       1000
`define BLINK_MS        500
`define SHIFT_TIME_S    2
`define SEC_CYCLES      (`CLK_HZ)
`define RETRIG_CYCLES   (`CLK_HZ / 1000 * `RETRIG_MS)
`define BLINK_CYCLES    (`CLK_HZ / 1000 * `BLINK_MS)
`define LOG_DEPTH       16
`define LOG_EV_BYPASS   2'h0
`define LOG_EV_CLEAR    2'h1
`define LOG_EV_NODES    2'h2
`endif

// ===== hw/deadman_pkg.sv
package deadman_pkg;
   typedef enum logic [1:0] {VALVE_VIA_KEY, VALVE_DIRECT} valve_mode_t;
   typedef enum logic [1:0] {DM_OFF, DM_ON, DM_ON_BYPASS} dm_setting_t;
   typedef struct packed {
      logic start_key;
      logic stop_key;
      logic estop_key;
      logic deadman_key;
      logic shift_key;
      logic unroll_key;
      logic rollup_key;
   } keys_t;
   typedef struct packed {
      logic [31:0] stamp;
      logic [31:0] duration;
      logic [1:0]  event_code;
   } log_entry_t;
   typedef struct packed {
      logic yellow;
      logic green;
      logic red;
   } leds_t;
endpackage : deadman_pkg

// ===== hw/log_memory.sv
module log_memory #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 66
) (
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire logic                     ce,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic      [WIDTH-1:0]         rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clock) begin
      if (ce && wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_data <= '0;
      end else if (ce) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : log_memory

// ===== hw/amp_status.sv
`include "deadman_cfg.svh"
module amp_status
   import deadman_pkg::*;
#(
   parameter int SEC_CYC   = `SEC_CYCLES,
   parameter int BLINK_CYC = `BLINK_CYCLES
) (
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire logic               ce,
   input  wire logic               amp_on,
   input  wire logic               in_charger,
   input  wire logic               sensor_connected,
   input  wire logic               sensor_wet,
   input  wire logic               sensor_warming,
   input  wire logic               radio_ok,
   input  wire logic               func_fault,
   input  wire logic               batt_full,
   input  wire logic               batt_fault,
   output logic                    fill_release,
   output logic                    auto_off,
   output deadman_pkg::leds_t      leds
);
   typedef struct packed {
      logic [31:0] blink_cnt;
      logic        blink;
      logic [31:0] sec_cnt;
      logic [7:0]  test_s;
      logic [7:0]  loss_s;
      logic        in_charger_d;
      logic        off;
      leds_t       leds;
      logic        release_q;
   } st_t;
   st_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.in_charger_d = in_charger;
      if (s_r.blink_cnt >= 32'(BLINK_CYC - 1)) begin
         s_nxt.blink_cnt = '0;
         s_nxt.blink     = ~s_r.blink;
      end else begin
         s_nxt.blink_cnt = s_r.blink_cnt + 32'h1;
      end
      if (s_r.sec_cnt >= 32'(SEC_CYC - 1)) begin
         s_nxt.sec_cnt = '0;
      end else begin
         s_nxt.sec_cnt = s_r.sec_cnt + 32'h1;
      end
      // (R17) lamp test on insertion
      if (in_charger && !s_r.in_charger_d) begin
         s_nxt.test_s = 8'(`LAMP_TEST_S);
      end else if (s_r.sec_cnt == '0 && s_r.test_s != 8'h0) begin
         s_nxt.test_s = s_r.test_s - 8'h1;
      end
      // (R21) sensor loss auto off
      if (!amp_on || sensor_connected || in_charger) begin
         s_nxt.loss_s = '0;
         s_nxt.off    = 1'b0;
      end else if (s_r.sec_cnt == '0) begin
         if (s_r.loss_s > 8'(`SENSOR_LOSS_S)) begin
            s_nxt.off = 1'b1;
         end else begin
            s_nxt.loss_s = s_r.loss_s + 8'h1;
         end
      end
      // (R16) release only on dry sensor
      s_nxt.release_q = amp_on && !in_charger && sensor_connected && !sensor_warming
                        && !sensor_wet && !func_fault && !s_r.off;
      if (in_charger) begin
         if (s_r.test_s != 8'h0) begin
            s_nxt.leds = '{yellow: 1'b1, green: 1'b1, red: 1'b1};
         end else begin
            // (R18) charger encoding
            s_nxt.leds = '{yellow: 1'b0, green: batt_full || batt_fault, red: !batt_full || batt_fault};
         end
      end else if (amp_on && !s_r.off) begin
         // (R19) power indicator
         s_nxt.leds.yellow = radio_ok ? 1'b1 : s_r.blink;
         // (R20) blink codes
         s_nxt.leds.green  = sensor_warming ? s_r.blink : (sensor_connected && !sensor_wet && !func_fault);
         s_nxt.leds.red    = func_fault ? s_r.blink : (sensor_connected && sensor_wet);
      end else begin
         s_nxt.leds = '0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign fill_release = s_r.release_q;
   assign auto_off     = s_r.off;
   assign leds         = s_r.leds;

   // (R21) off needs long loss
   property p_off_cause;
      @(posedge clock) disable iff (rst) $rose(s_r.off) |-> $past(s_r.loss_s) > 8'(`SENSOR_LOSS_S);
   endproperty
   a_off_cause: assert property (p_off_cause) else $error("auto off without sensor loss"); // (R21)
   // (R18) charging power dark
   property p_charge_dark;
      @(posedge clock) disable iff (rst) ce && in_charger && $past(in_charger) && s_r.test_s == 8'h0
         |=> !leds.yellow;
   endproperty
   a_charge_dark: assert property (p_charge_dark) else $error("power lit in charger"); // (R18)
   // (R16) wet never released
   property p_wet_no_release;
      @(posedge clock) disable iff (rst) ce && sensor_wet |=> !fill_release;
   endproperty
   a_wet_no_release: assert property (p_wet_no_release) else $error("release with wet sensor"); // (R16)
   c_lamp_test: cover property (@(posedge clock) disable iff (rst) s_r.test_s != 8'h0 && leds.red);
endmodule : amp_status

// ===== verification/flow_computer_model.sv
module flow_computer_model (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic retrigger_msg,
   input  wire logic finish_req,
   output logic      discharge_finished,
   output int        retrig_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic req_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         req_r              <= 1'b0;
         discharge_finished <= 1'b0;
         retrig_count       <= 0;
      end else begin
         req_r              <= finish_req;
         // one-cycle end-of-discharge pulse
         discharge_finished <= finish_req & ~req_r;
         if (retrigger_msg) retrig_count <= retrig_count + 1;
      end
   end
endmodule : flow_computer_model

// ===== verification/deadman_discharge_supervisor_bench.sv
`include "deadman_cfg.svh"
module deadman_discharge_supervisor_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import deadman_pkg::*;
   logic clock = 1'b0, rst = 1'b1, ce, flow_computer_present, bypass_request, remote_power_on, log_clear;
   logic radio_nodes_changed, discharge_finished, amp_on, in_charger, sensor_connected, sensor_wet;
   logic sensor_warming, radio_ok, func_fault, batt_full, batt_fault, finish_req;
   logic discharge_active, deadman_warning, forced_stop, retrigger_msg, machine_off, bypass_active;
   logic unroll_out, rollup_out, fill_release, amp_auto_off;
   logic [3:0] log_rd_addr;
   logic [4:0] log_count;
   keys_t keys_pin;
   valve_mode_t valve_control_setting;
   dm_setting_t deadman_setting;
   leds_t amp_leds;
   log_entry_t log_rd_data;
   int n_mismatch = 0, n_compared = 0, retrig_count;
   always #12.5 clock = ~clock;
   deadman_discharge_supervisor #(.SEC_CYC(10), .RETRIG_CYC(5), .BLINK_CYC(3), .LOG_DEPTH(16)) u_dut (
      .clock, .rst, .ce, .keys_pin, .flow_computer_present, .valve_control_setting, .deadman_setting,
      .bypass_request, .remote_power_on, .log_clear, .radio_nodes_changed, .discharge_finished, .log_rd_addr,
      .amp_on, .in_charger, .sensor_connected, .sensor_wet, .sensor_warming, .radio_ok, .func_fault, .batt_full,
      .batt_fault, .discharge_active, .deadman_warning, .forced_stop, .retrigger_msg, .machine_off,
      .bypass_active, .unroll_out, .rollup_out, .fill_release, .amp_auto_off, .amp_leds, .log_rd_data, .log_count);
   flow_computer_model u_fc (.clock, .rst, .retrigger_msg, .finish_req, .discharge_finished, .retrig_count);
   task automatic complete_run();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask : chk
   function automatic logic pick(input int s);
      case (s)
         0: return discharge_active;
         1: return deadman_warning;
         2: return forced_stop;
         3: return machine_off;
         4: return unroll_out;
         5: return rollup_out;
         default: return fill_release;
      endcase
   endfunction : pick
   // bounded wait on an output, then compared
   task automatic wait_sig(input int s, input logic v, input int lim);
      int n;
      n = 0;
      #1;
      while (pick(s) !== v && n < lim) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk($sformatf("output %0d", s), v, pick(s));
      if (pick(s) !== v) complete_run();
   endtask : wait_sig
   task automatic hold(input int i, input logic v);
      @(posedge clock);
      keys_pin[i] <= v;
      repeat (4) @(posedge clock);
   endtask : hold
   task automatic press(input int i);
      hold(i, 1'b1);
      hold(i, 1'b0);
   endtask : press
   initial begin
      {ce, flow_computer_present, bypass_request, remote_power_on, log_clear, radio_nodes_changed} = 6'h34;
      {amp_on, in_charger, sensor_connected, sensor_wet, sensor_warming, radio_ok} = 6'h29;
      {func_fault, batt_full, batt_fault, finish_req} = 4'h0;
      log_rd_addr = 4'h0;
      keys_pin = '0;
      valve_control_setting = VALVE_VIA_KEY;
      deadman_setting = DM_ON;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk("idle", 1'b0, discharge_active);
      wait_sig(6, 1'b1, 20);
      chk("green", 1'b1, amp_leds.green);
      press(6);
      wait_sig(0, 1'b1, 10);
      repeat (200) @(posedge clock);
      press(3);
      repeat (250) @(posedge clock);
      #1;
      chk("warn early", 1'b0, deadman_warning);
      wait_sig(1, 1'b1, 100);
      chk("retrigger", 1'b1, retrig_count > 0);
      press(3);
      wait_sig(1, 1'b0, 10);
      wait_sig(2, 1'b1, 450);
      wait_sig(0, 1'b0, 10);
      press(6);
      wait_sig(0, 1'b1, 10);
      press(5);
      wait_sig(0, 1'b0, 10);
      chk("warn idle", 1'b0, deadman_warning);
      press(2);
      hold(1, 1'b1);
      wait_sig(4, 1'b1, 10);
      hold(1, 1'b0);
      wait_sig(4, 1'b0, 10);
      deadman_setting <= DM_OFF;
      // first start after a stop only clears the finished state
      press(6);
      press(6);
      wait_sig(0, 1'b1, 10);
      repeat (450) @(posedge clock);
      #1;
      chk("no warn", 1'b0, deadman_warning);
      chk("no stop", 1'b0, forced_stop);
      finish_req <= 1'b1;
      wait_sig(0, 1'b0, 10);
      press(2);
      hold(0, 1'b1);
      wait_sig(5, 1'b1, 10);
      hold(0, 1'b0);
      press(4);
      wait_sig(3, 1'b1, 10);
      sensor_wet <= 1'b1;
      wait_sig(6, 1'b0, 10);
      chk("red", 1'b1, amp_leds.red);
      // stand-alone: start on rising release, second rise starts
      flow_computer_present <= 1'b0;
      valve_control_setting <= VALVE_DIRECT;
      sensor_wet <= 1'b0;
      wait_sig(6, 1'b1, 10);
      sensor_wet <= 1'b1;
      wait_sig(6, 1'b0, 10);
      sensor_wet <= 1'b0;
      wait_sig(0, 1'b1, 10);
      deadman_setting <= DM_ON_BYPASS;
      bypass_request <= 1'b1;
      @(posedge clock);
      bypass_request <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk("bypass", 1'b1, bypass_active);
      chk("bypass log", 1'b1, log_count == 5'h1);
      remote_power_on <= 1'b0;
      log_clear <= 1'b1;
      log_rd_addr <= 4'h1;
      @(posedge clock);
      log_clear <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk("bypass off", 1'b0, bypass_active);
      chk("clear log", 1'b1, log_count == 5'h1 && log_rd_data.event_code == `LOG_EV_CLEAR);
      radio_nodes_changed <= 1'b1;
      @(posedge clock);
      radio_nodes_changed <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk("node log", 1'b1, log_count == 5'h2);
      complete_run();
   end
endmodule : deadman_discharge_supervisor_bench
